// ==== hdl/imc_top.sv ====
// indirect shared memory / look-up table access and operating control register
`timescale 1ns/1ps
`default_nettype none
module imc_top (
	input  wire logic                              clk,
	input  wire logic                              rstn,
	input  wire logic                              flush_rst,
	input  wire logic [4:0]                        reg_addr,
	input  wire logic [15:0]                       reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [15:0]                       reg_rdata,
	output logic                                   reg_rvalid,
	output logic                                   mem_req,
	output logic                                   mem_we,
	output logic                                   mem_bank,
	output logic      [imc_pkg::ROW_W-1:0]         mem_row,
	output logic      [imc_pkg::ROW_BITS-1:0]      mem_wdata,
	input  wire logic [imc_pkg::ROW_BITS-1:0]      mem_rdata,
	input  wire logic                              mem_rvalid,
	output logic      [imc_pkg::PTR_W-1:0]         lut_addr,
	output logic                                   lut_wr,
	output logic      [15:0]                       lut_wdata,
	input  wire logic [15:0]                       lut_rdata,
	output logic                                   proc_err_evt,
	output logic                                   pico_core_reset_hold,
	output logic                                   standby,
	output logic                                   idle_color,
	output logic                                   expected_color,
	input  wire logic                              expected_color_now,
	input  wire logic                              pkt_cycle,
	input  wire logic [imc_pkg::NUM_PORTS-1:0]     grant_vec,
	input  wire logic                              pkt_rx,
	input  wire logic [imc_pkg::PORT_W-1:0]        pkt_dest,
	output logic                                   pkt_discard,
	output logic                                   fc_violation_evt,
	input  wire logic                              int_req,
	output logic                                   int_n_o,
	output logic                                   int_n_oe
);
	logic [15:0]                  mode_r;
	logic [imc_pkg::PTR_W-1:0]    ptr_r;
	logic                         ptr_sel_r;
	logic [imc_pkg::ROW_W-1:0]    row_r;
	logic                         bank_r;
	logic [15:0]                  stg_r [imc_pkg::ROW_HW];
	logic                         stg_valid_r;
	logic                         rd_pending_r;
	logic                         mem_req_r;
	logic                         mem_we_r;
	logic [15:0]                  rdata_r;
	logic                         rvalid_r;
	logic                         lut_wr_r;
	logic [15:0]                  lut_wdata_r;
	logic                         err_r;
	logic                         idle_r;
	logic                         disc_r;
	logic                         fcv_r;
	logic [imc_pkg::NUM_PORTS-1:0] ghist_r [imc_pkg::GRANT_DEPTH];
	logic [imc_pkg::NUM_PORTS-1:0] recent_grant;
	logic                         wr_mode;
	logic                         wr_ptr;
	logic                         wr_data;
	logic                         rd_data;
	logic                         wr_row;
	logic                         wr_cmd;
	logic                         stg_hit;
	logic [3:0]                   hw_idx;
	logic                         cmd_read;
	logic                         cmd_write;

	assign wr_mode   = reg_wr && (reg_addr == imc_pkg::ADDR_MODE);
	assign wr_ptr    = reg_wr && (reg_addr == imc_pkg::ADDR_TBL_PTR);
	assign wr_data   = reg_wr && (reg_addr == imc_pkg::ADDR_TBL_DATA);
	assign rd_data   = reg_rd && (reg_addr == imc_pkg::ADDR_TBL_DATA);
	assign wr_row    = reg_wr && (reg_addr == imc_pkg::ADDR_ROW_ADDR);
	assign wr_cmd    = reg_wr && (reg_addr == imc_pkg::ADDR_COMMAND);
	assign cmd_read  = wr_cmd && reg_wdata[imc_pkg::CMD_ROW_READ];
	// a row read in the same write wins over a row write
	assign cmd_write = wr_cmd && reg_wdata[imc_pkg::CMD_ROW_WRITE] && !cmd_read;
	// halfword index of the staging row; pointer past the row end hits nothing
	assign hw_idx    = ptr_r[4:1];
	assign stg_hit   = !ptr_sel_r && (ptr_r <= imc_pkg::ROW_LAST_PTR);

	// mode register; flush reset returns it to standby like power-on
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= imc_pkg::MODE_RESET;
		end else if (flush_rst) begin
			mode_r <= imc_pkg::MODE_RESET;
		end else if (wr_mode) begin
			// standby can be cleared by software but never set
			mode_r <= (reg_wdata & imc_pkg::MODE_WR_MASK)
				& {mode_r[imc_pkg::MODE_STANDBY], 15'h7FFF};
		end
	end

	// table pointer with select bit and auto increment
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptr_r     <= '0;
			ptr_sel_r <= 1'b0;
		end else if (flush_rst) begin
			ptr_r     <= '0;
			ptr_sel_r <= 1'b0;
		end else if (wr_ptr) begin
			ptr_r     <= reg_wdata[imc_pkg::PTR_W-1:0];
			ptr_sel_r <= reg_wdata[imc_pkg::PTR_SEL_BIT];
		end else if (wr_data || rd_data) begin
			ptr_r <= ptr_r + imc_pkg::PTR_STEP;
		end
	end

	// row address and bank choice
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			row_r  <= '0;
			bank_r <= 1'b0;
		end else if (flush_rst) begin
			row_r  <= '0;
			bank_r <= 1'b0;
		end else if (wr_row) begin
			row_r  <= reg_wdata[imc_pkg::ROW_W-1:0];
			bank_r <= reg_wdata[imc_pkg::ROW_BANK_BIT];
		end
	end

	// staging row: loaded whole from memory or one halfword from the port
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < imc_pkg::ROW_HW; i++) begin
				stg_r[i] <= '0;
			end
		end else if (flush_rst) begin
			for (int i = 0; i < imc_pkg::ROW_HW; i++) begin
				stg_r[i] <= '0;
			end
		end else if (rd_pending_r && mem_rvalid) begin
			for (int i = 0; i < imc_pkg::ROW_HW; i++) begin
				stg_r[i] <= mem_rdata[i*16 +: 16];
			end
		end else if (wr_data && stg_hit) begin
			stg_r[hw_idx] <= reg_wdata;
		end
	end

	// row read tracking; a new read command beats a completion in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_pending_r <= 1'b0;
			stg_valid_r  <= 1'b0;
		end else if (flush_rst) begin
			rd_pending_r <= 1'b0;
			stg_valid_r  <= 1'b0;
		end else if (cmd_read) begin
			rd_pending_r <= 1'b1;
			stg_valid_r  <= 1'b0;
		end else if (rd_pending_r && mem_rvalid) begin
			rd_pending_r <= 1'b0;
			stg_valid_r  <= 1'b1;
		end
	end

	// memory request pulses; write data is the staging row itself
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_req_r <= 1'b0;
			mem_we_r  <= 1'b0;
		end else begin
			mem_req_r <= (cmd_read || cmd_write) && !flush_rst;
			mem_we_r  <= cmd_write && !flush_rst;
		end
	end

	assign mem_req  = mem_req_r;
	assign mem_we   = mem_we_r;
	assign mem_bank = bank_r;
	assign mem_row  = row_r;

	// whole row presented at once so memory sees one atomic write
	for (genvar g = 0; g < imc_pkg::ROW_HW; g++) begin : g_wdata
		assign mem_wdata[g*16 +: 16] = stg_r[g];
	end

	// look-up table write strobe and data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lut_wr_r    <= 1'b0;
			lut_wdata_r <= '0;
		end else begin
			lut_wr_r <= wr_data && ptr_sel_r && !flush_rst;
			if (wr_data && ptr_sel_r) begin
				lut_wdata_r <= reg_wdata;
			end
		end
	end

	// lut_addr_r trails the pointer by one cycle, aligned with the strobe
	logic [imc_pkg::PTR_W-1:0] lut_addr_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lut_addr_r <= '0;
		end else if (wr_data || rd_data) begin
			lut_addr_r <= ptr_r;
		end
	end

	// a pending table write keeps its address so back to back fills land right;
	// limitation: a data read right behind a table write sees the written address
	assign lut_addr  = lut_wr_r ? lut_addr_r : ((wr_data || rd_data) ? ptr_r : lut_addr_r);
	assign lut_wr    = lut_wr_r;
	assign lut_wdata = lut_wdata_r;

	// register read path, one cycle latency
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					imc_pkg::ADDR_MODE: begin
						rdata_r <= {mode_r[15:9], 1'b0, imc_pkg::VERSION_LEVEL};
					end
					imc_pkg::ADDR_TBL_PTR: begin
						rdata_r <= {ptr_sel_r, 7'h00, ptr_r};
					end
					imc_pkg::ADDR_TBL_DATA: begin
						if (ptr_sel_r) begin
							rdata_r <= lut_rdata;
						end else if (stg_hit) begin
							rdata_r <= stg_r[hw_idx];
						end else begin
							rdata_r <= '0;
						end
					end
					imc_pkg::ADDR_ROW_ADDR: begin
						rdata_r <= {bank_r, 5'h00, row_r};
					end
					default: begin
						rdata_r <= '0;
					end
				endcase
			end
		end
	end

	assign reg_rdata  = rdata_r;
	assign reg_rvalid = rvalid_r;

	// early staging read while a row read is outstanding
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_r <= 1'b0;
		end else begin
			err_r <= rd_data && !ptr_sel_r && rd_pending_r && !stg_valid_r;
		end
	end

	assign proc_err_evt = err_r;

	assign pico_core_reset_hold = mode_r[imc_pkg::MODE_PICO_RST];
	assign standby              = mode_r[imc_pkg::MODE_STANDBY];
	assign expected_color       = mode_r[imc_pkg::MODE_EXP_CLR];

	// idle colour: forced value or the colour the link currently expects
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_r <= 1'b0;
		end else if (mode_r[imc_pkg::MODE_IDLE_FRC]) begin
			idle_r <= mode_r[imc_pkg::MODE_IDLE_CLR];
		end else begin
			idle_r <= expected_color_now;
		end
	end

	assign idle_color = idle_r;

	// grant history over the last packet cycles, flushed in standby
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < imc_pkg::GRANT_DEPTH; i++) begin
				ghist_r[i] <= '0;
			end
		end else if (standby) begin
			for (int i = 0; i < imc_pkg::GRANT_DEPTH; i++) begin
				ghist_r[i] <= '0;
			end
		end else if (pkt_cycle) begin
			ghist_r[0] <= grant_vec;
			for (int i = 1; i < imc_pkg::GRANT_DEPTH; i++) begin
				ghist_r[i] <= ghist_r[i-1];
			end
		end
	end

	for (genvar p = 0; p < imc_pkg::NUM_PORTS; p++) begin : g_recent
		logic any;
		always_comb begin
			any = 1'b0;
			for (int i = 0; i < imc_pkg::GRANT_DEPTH; i++) begin
				any = any | ghist_r[i][p];
			end
		end
		assign recent_grant[p] = any;
	end

	// discard and violation report for ungranted destinations
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disc_r <= 1'b0;
			fcv_r  <= 1'b0;
		end else begin
			disc_r <= pkt_rx && !standby && mode_r[imc_pkg::MODE_FC_CHECK]
				&& !recent_grant[pkt_dest];
			fcv_r  <= pkt_rx && !standby && mode_r[imc_pkg::MODE_FC_CHECK]
				&& !recent_grant[pkt_dest];
		end
	end

	assign pkt_discard      = disc_r;
	assign fc_violation_evt = fcv_r;

	// open-drain interrupt: driven low only when requested and not masked
	assign int_n_o  = 1'b0;
	assign int_n_oe = int_req && !mode_r[imc_pkg::MODE_GLB_MASK];
endmodule
`default_nettype wire

// ==== hdl/imc_pkg.sv ====
// constants for the indirect memory access and mode control block
package imc_pkg;
	localparam logic [4:0]  ADDR_MODE      = 5'h00;
	localparam logic [4:0]  ADDR_TBL_PTR   = 5'h14;
	localparam logic [4:0]  ADDR_TBL_DATA  = 5'h15;
	localparam logic [4:0]  ADDR_ROW_ADDR  = 5'h16;
	localparam logic [4:0]  ADDR_COMMAND   = 5'h17;

	// version value is arbitrary, not a real part's revision
	localparam logic [7:0]  VERSION_LEVEL  = 8'h5A;

	localparam int          MODE_VER_LSB   = 0;
	localparam int          MODE_VER_MSB   = 7;
	localparam int          MODE_PICO_RST  = 9;
	localparam int          MODE_FC_CHECK  = 10;
	localparam int          MODE_IDLE_FRC  = 11;
	localparam int          MODE_IDLE_CLR  = 12;
	localparam int          MODE_EXP_CLR   = 13;
	localparam int          MODE_GLB_MASK  = 14;
	localparam int          MODE_STANDBY   = 15;
	localparam logic [15:0] MODE_WR_MASK   = 16'hFE00;
	localparam logic [15:0] MODE_RESET     = 16'h8000;

	localparam int          PTR_W          = 8;
	localparam int          PTR_SEL_BIT    = 15;
	localparam logic [7:0]  PTR_STEP       = 8'h02;

	localparam int          ROW_W          = 10;
	localparam int          ROW_BANK_BIT   = 15;

	localparam int          CMD_ROW_READ   = 0;
	localparam int          CMD_ROW_WRITE  = 1;

	localparam int          ROW_BYTES      = 20;
	localparam int          ROW_HW         = ROW_BYTES / 2;
	localparam int          ROW_BITS       = ROW_BYTES * 8;
	localparam logic [7:0]  ROW_LAST_PTR   = 8'h12;

	localparam int          NUM_PORTS      = 16;
	localparam int          PORT_W         = 4;
	localparam int          GRANT_DEPTH    = 8;
endpackage

// ==== verification/imc_assertions.sv ====
// port-level checks for the indirect access and operating control block
`timescale 1ns/1ps
`default_nettype none
module imc_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        flush_rst,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        proc_err_evt,
	input wire logic        pico_core_reset_hold,
	input wire logic        standby,
	input wire logic        pkt_rx,
	input wire logic        pkt_discard,
	input wire logic        fc_violation_evt,
	input wire logic        int_n_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// a flush in the same cycle overrides any register write
	wire logic mw = reg_wr && !flush_rst && reg_addr == imc_pkg::ADDR_MODE;
	wire logic cw = reg_wr && reg_addr == imc_pkg::ADDR_COMMAND;
	wire logic dr = reg_rd && reg_addr == imc_pkg::ADDR_TBL_DATA;
	property p_rv; reg_rd |=> reg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_ver; reg_rd && reg_addr == imc_pkg::ADDR_MODE |=> reg_rdata[7:0] == imc_pkg::VERSION_LEVEL; endproperty
	a_ver: assert property (p_ver) else $error("version field wrong");
	property p_pico; mw |=> pico_core_reset_hold == $past(reg_wdata[9]); endproperty
	a_pico: assert property (p_pico) else $error("pico hold not written");
	property p_stby; $rose(standby) |-> $past(flush_rst); endproperty
	a_stby: assert property (p_stby) else $error("standby set without flush");
	property p_mask; mw && reg_wdata[14] |=> !int_n_oe; endproperty
	a_mask: assert property (p_mask) else $error("masked pin driven");
	property p_req; cw && !flush_rst && reg_wdata[1:0] != 2'h0 |=> mem_req && mem_we == !$past(reg_wdata[0]); endproperty
	a_req: assert property (p_req) else $error("row command not issued");
	property p_reqc; mem_req |-> $past(cw); endproperty
	a_reqc: assert property (p_reqc) else $error("spurious row request");
	property p_err; proc_err_evt |-> $past(dr); endproperty
	a_err: assert property (p_err) else $error("error without data read");
	property p_disc; pkt_discard |-> fc_violation_evt && $past(pkt_rx); endproperty
	a_disc: assert property (p_disc) else $error("discard without packet");
endmodule
`default_nettype wire

// ==== verification/imc_mem_model.sv ====
// shared row memory and look-up table behind the block
`timescale 1ns/1ps
`default_nettype none
module imc_mem_model (
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic                         slow,
	input  wire logic                         mem_req,
	input  wire logic                         mem_we,
	input  wire logic                         mem_bank,
	input  wire logic [imc_pkg::ROW_W-1:0]    mem_row,
	input  wire logic [imc_pkg::ROW_BITS-1:0] mem_wdata,
	output logic      [imc_pkg::ROW_BITS-1:0] mem_rdata,
	output logic                              mem_rvalid,
	input  wire logic [imc_pkg::PTR_W-1:0]    lut_addr,
	input  wire logic                         lut_wr,
	input  wire logic [15:0]                  lut_wdata,
	output logic      [15:0]                  lut_rdata
);
	logic [imc_pkg::ROW_BITS-1:0] rows [2048];
	logic [imc_pkg::ROW_BITS-1:0] hold;
	logic [15:0]                  lut [256];
	int                           cnt;
	assign lut_rdata = lut[lut_addr];
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			mem_rvalid <= 1'b0;
			mem_rdata <= '0;
		end else begin
			mem_rvalid <= 1'b0;
			// data lines carry the row in the valid cycle and invert every cycle otherwise
			mem_rdata <= ~mem_rdata;
			if (mem_req && mem_we)
				rows[{mem_bank, mem_row}] <= mem_wdata;
			if (mem_req && !mem_we) begin
				hold <= rows[{mem_bank, mem_row}];
				cnt <= slow ? 6 : 1;
			end else if (cnt == 1) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= hold;
				cnt <= 0;
			end else if (cnt > 1)
				cnt <= cnt - 1;
			if (lut_wr)
				lut[lut_addr] <= lut_wdata;
		end
	end
endmodule
`default_nettype wire

// ==== verification/indirect_memory_access_and_mode_control_test.sv ====
// self-checking bench for the indirect access and operating control block
`timescale 1ns/1ps
`default_nettype none
module indirect_memory_access_and_mode_control_test;
	logic clk = 1'b0, rstn = 1'b0, flush_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
	logic pkt_cycle = 1'b0, pkt_rx = 1'b0, int_req = 1'b0, expected_color_now = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, grant_vec = 16'h0000;
	logic [3:0] pkt_dest = 4'h0;
	logic [15:0] reg_rdata, lut_wdata, lut_rdata, b, d [10];
	logic [7:0] lut_addr;
	logic [9:0] mem_row;
	logic [159:0] mem_wdata, mem_rdata;
	logic reg_rvalid, mem_req, mem_we, mem_bank, mem_rvalid, lut_wr, proc_err_evt, standby;
	logic pico_core_reset_hold, idle_color, expected_color, pkt_discard, fc_violation_evt;
	logic int_n_o, int_n_oe;
	logic [16:0] expq [$];
	logic [16:0] ev;
	int n_errors = 0, tests_run = 0, n_err = 0, n_disc = 0, n_fcv = 0, k;
	always #4 clk = ~clk;
	imc_top u_dut (.*);
	imc_mem_model u_mem (.*);
	task chk_word(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chk_bit(input logic g, input logic e);
		chk_word({15'h0000, g}, {15'h0000, e});
	endtask
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		reg_wdata = ~v;
	endtask
	// bit 16 of an expectation marks a value that is not compared
	task rd(input logic [4:0] a, input logic [16:0] e);
		@(posedge clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		expq.push_back(e);
		@(posedge clk);
		#1 reg_rd = 1'b0;
	endtask
	task pc(input logic [15:0] g, input logic rx, input logic [3:0] dst);
		@(posedge clk);
		#1 grant_vec = g;
		pkt_dest = dst;
		pkt_cycle = !rx;
		pkt_rx = rx;
		@(posedge clk);
		#1 pkt_cycle = 1'b0;
		pkt_rx = 1'b0;
		grant_vec = ~g;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1) begin
			if (expq.size() == 0)
				chk_word(16'h0000, 16'hFFFF);
			else begin
				ev = expq.pop_front();
				if (!ev[16])
					chk_word(reg_rdata, ev[15:0]);
			end
		end
		if (proc_err_evt === 1'b1) n_err++;
		if (pkt_discard === 1'b1) n_disc++;
		if (fc_violation_evt === 1'b1) n_fcv++;
	end
	initial begin
		#100000;
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'h4B704E7E));
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		rd(imc_pkg::ADDR_MODE, {1'b0, 8'h80, imc_pkg::VERSION_LEVEL});
		rd(imc_pkg::ADDR_TBL_PTR, 17'h00000);
		chk_bit(standby, 1'b1);
		wr(imc_pkg::ADDR_MODE, 16'h7EFF);
		rd(imc_pkg::ADDR_MODE, {1'b0, 8'h7E, imc_pkg::VERSION_LEVEL});
		chk_bit(pico_core_reset_hold, 1'b1);
		chk_bit(standby, 1'b0);
		chk_bit(expected_color, 1'b1);
		chk_bit(idle_color, 1'b1);
		int_req = 1'b1;
		#1 chk_bit(int_n_oe, 1'b0);
		wr(imc_pkg::ADDR_MODE, 16'h8800);
		rd(imc_pkg::ADDR_MODE, {1'b0, 8'h08, imc_pkg::VERSION_LEVEL});
		chk_bit(idle_color, 1'b0);
		chk_bit(int_n_oe, 1'b1);
		chk_bit(int_n_o, 1'b0);
		expected_color_now = 1'b1;
		wr(imc_pkg::ADDR_MODE, 16'h0000);
		rd(imc_pkg::ADDR_MODE, {1'b0, 8'h00, imc_pkg::VERSION_LEVEL});
		chk_bit(idle_color, 1'b1);
		@(posedge clk);
		#1 flush_rst = 1'b1;
		@(posedge clk);
		#1 flush_rst = 1'b0;
		int_req = 1'b0;
		rd(imc_pkg::ADDR_MODE, {1'b0, 8'h80, imc_pkg::VERSION_LEVEL});
		$display("mode register test done");
		b = 16'($urandom);
		wr(imc_pkg::ADDR_ROW_ADDR, b & 16'h83FF);
		chk_word({mem_bank, 5'h00, mem_row}, b & 16'h83FF);
		rd(imc_pkg::ADDR_ROW_ADDR, {1'b0, b & 16'h83FF});
		wr(imc_pkg::ADDR_TBL_PTR, 16'h0000);
		for (k = 0; k < 10; k++) begin
			d[k] = 16'($urandom);
			wr(imc_pkg::ADDR_TBL_DATA, d[k]);
		end
		rd(imc_pkg::ADDR_TBL_PTR, 17'h00014);
		wr(imc_pkg::ADDR_COMMAND, 16'h0002);
		wr(imc_pkg::ADDR_TBL_PTR, 16'h0000);
		for (k = 0; k < 10; k++)
			wr(imc_pkg::ADDR_TBL_DATA, ~d[k]);
		slow = 1'b1;
		wr(imc_pkg::ADDR_COMMAND, 16'h0001);
		rd(imc_pkg::ADDR_TBL_DATA, 17'h10000);
		for (k = 0; k < 40 && mem_rvalid !== 1'b1; k++)
			@(negedge clk);
		chk_bit(mem_rvalid, 1'b1);
		wr(imc_pkg::ADDR_TBL_PTR, 16'h0000);
		for (k = 0; k < 10; k++)
			rd(imc_pkg::ADDR_TBL_DATA, {1'b0, d[k]});
		rd(imc_pkg::ADDR_TBL_DATA, 17'h00000);
		chk_word(n_err[15:0], 16'h0001);
		$display("row staging test done");
		b = 16'h8000 | (16'($urandom) & 16'h00F0);
		wr(imc_pkg::ADDR_TBL_PTR, b);
		for (k = 0; k < 3; k++)
			wr(imc_pkg::ADDR_TBL_DATA, ~d[k + 3]);
		wr(imc_pkg::ADDR_TBL_PTR, b);
		for (k = 0; k < 3; k++)
			rd(imc_pkg::ADDR_TBL_DATA, {1'b0, ~d[k + 3]});
		rd(imc_pkg::ADDR_TBL_PTR, {1'b0, b + 16'h0006});
		wr(imc_pkg::ADDR_TBL_PTR, 16'h0000);
		rd(imc_pkg::ADDR_TBL_DATA, {1'b0, d[0]});
		// both command bits: the row read wins, so staging goes invalid again
		wr(imc_pkg::ADDR_COMMAND, 16'h0003);
		rd(imc_pkg::ADDR_TBL_DATA, 17'h10000);
		repeat (10) @(posedge clk);
		chk_word(n_err[15:0], 16'h0002);
		$display("table select test done");
		wr(imc_pkg::ADDR_MODE, 16'h0C00);
		pc(16'h0008, 1'b0, 4'h0);
		for (k = 0; k < 7; k++)
			pc(16'h0000, 1'b0, 4'h0);
		pc(16'h0000, 1'b1, 4'h3);
		pc(16'h0000, 1'b1, 4'h5);
		pc(16'h0000, 1'b0, 4'h0);
		pc(16'h0000, 1'b1, 4'h3);
		wr(imc_pkg::ADDR_MODE, 16'h0800);
		pc(16'h0000, 1'b1, 4'h5);
		repeat (2) @(posedge clk);
		chk_word(n_disc[15:0], 16'h0002);
		chk_word(n_fcv[15:0], 16'h0002);
		$display("flow check test done");
		tally_and_finish;
	end
endmodule
bind imc_top imc_assertions u_chk (.*);
`default_nettype wire
